// ===== include/mprs_pkg.sv
// Purpose: constants and types for the module power and reset supervisor
// Assumes: 40 MHz ref_clk
// Notes: times are given in microseconds and turned into cycle counts here
package mprs_pkg;
   localparam int CLK_MHZ = 40;
   // configuration timeout after the processor leaves reset
   localparam int CFG_TIMEOUT_US = 100000;
   localparam int CFG_TIMEOUT_CYC = CFG_TIMEOUT_US * CLK_MHZ;
   // default watchdog window, counted from the previous kick
   localparam int WD_OPEN_US = 1000;
   localparam int WD_CLOSE_US = 10000;
   localparam int WD_OPEN_CYC = WD_OPEN_US * CLK_MHZ;
   localparam int WD_CLOSE_CYC = WD_CLOSE_US * CLK_MHZ;
   // length of the warm reset pulse
   localparam int WARM_PULSE_US = 10;
   localparam int WARM_PULSE_CYC = WARM_PULSE_US * CLK_MHZ;
   // rail monitor low-pass filter length
   localparam int MON_FILT_US = 20;
   localparam int MON_FILT_CYC = MON_FILT_US * CLK_MHZ;
   localparam int CNT_W = 24;
   localparam int FILT_W = 12;
   // watchdog action per stage
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_WARM = 2'h1;
   localparam logic [1:0] ACT_HARD = 2'h2;
   // one-time-programmable defaults
   localparam logic [1:0] OTP_WD_ACT1 = ACT_WARM;
   localparam logic [1:0] OTP_WD_ACT2 = ACT_HARD;
   localparam logic OTP_MON_ACT = 1'b1;
   localparam logic [FILT_W-1:0] OTP_MON_FILT = FILT_W'(MON_FILT_CYC);
   typedef enum logic [1:0] {XCV_STANDBY, XCV_NORMAL, XCV_SLEEP} mprs_xcv_t;
   typedef enum logic [2:0] {PWR_OFF, PWR_PMIC, PWR_RUN} mprs_pwr_t;
   typedef enum logic [1:0] {WD_IDLE, WD_ARMED, WD_WARM, WD_RECOVER} mprs_wd_t;
endpackage

// ===== hw/mprs_rail_filter.sv
// Purpose: low-pass filter of one rail fault indication
// Assumes: fault input synchronous to ref_clk
// Notes: output rises only after the fault has held for flt_len cycles
`timescale 1ns/1ps
`default_nettype none
module mprs_rail_filter
   import mprs_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // filter
   input wire logic [FILT_W-1:0] flt_len,
   input wire logic fault_raw,
   output logic fault_ff
);
   logic [FILT_W-1:0] cnt_ff;
   logic [FILT_W-1:0] nxt_cnt;
   wire at_len = (cnt_ff >= flt_len);
   // a glitch restarts the count, so short excursions never reach the output
   assign nxt_cnt = !fault_raw ? '0 : (at_len ? cnt_ff : cnt_ff + 1'b1);
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         cnt_ff <= '0;
         fault_ff <= 1'b0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
         fault_ff <= fault_raw && at_len;
      end
   end
endmodule
`default_nettype wire

// ===== hw/mprs_supervisor.sv
// Operation
// - at power-up the transceiver controller starts in standby before anything else
// - in standby the regulator enable is driven active
// - regulator power good releases the power-management stage from reset
// - hard reset held until all generated rails are within range
// - processor configuration done moves transceiver from standby to normal
// - configuration timeout sends transceiver to sleep and drops regulator enable
// - bus wake-up in sleep returns to standby and re-enables regulator
// - first watchdog expiry asserts warm reset, not hard reset
// - expiry again after warm reset escalates to hard reset
// - watchdog window bounds and stage actions are programmable
// - under- or over-voltage on either processor rail forces hard reset
// - rail fault indications are low-pass filtered against short excursions
// - monitor settings default from OTP and are rewritable over I2C
// - inverted fatal fault output drives the transceiver reset
// - fatal fault puts transceiver to sleep and drops the inhibit output
// - re-enabling the regulator restarts the full power-up ordering
//
// Purpose: board power sequencing, watchdog and rail supervision for a radar module
// Assumes: all inputs synchronous to ref_clk; config writes arrive as decoded strobes
// Notes: configuration port stands in for the I2C register path of the PMIC
`timescale 1ns/1ps
`default_nettype none
module mprs_supervisor
   import mprs_pkg::*;
#(
   parameter int CFG_TIMEOUT = CFG_TIMEOUT_CYC,
   parameter int WD_OPEN = WD_OPEN_CYC,
   parameter int WD_CLOSE = WD_CLOSE_CYC,
   parameter int WARM_PULSE = WARM_PULSE_CYC
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // power chain
   input wire logic reg_power_good,
   input wire logic rails_in_range,
   output logic reg_enable,
   output logic supply_inhibit_ctl,
   output logic pmic_reset_n,
   // transceiver side
   input wire logic xcv_config_done,
   input wire logic bus_wakeup,
   output logic xcv_normal,
   // processor side
   input wire logic watchdog_kick_in,
   input wire logic fatal_fault_n,
   output logic radar_hard_reset_n,
   output logic radar_warm_reset_n,
   output logic watchdog_reset_out,
   // rail monitor faults
   input wire logic proc_io_rail_uv,
   input wire logic proc_io_rail_ov,
   input wire logic proc_core_rail_uv,
   input wire logic proc_core_rail_ov,
   // configuration writes
   input wire logic cfg_wd_wr,
   input wire logic [CNT_W-1:0] cfg_wd_open,
   input wire logic [CNT_W-1:0] cfg_wd_close,
   input wire logic [1:0] cfg_wd_act1,
   input wire logic [1:0] cfg_wd_act2,
   input wire logic cfg_mon_wr,
   input wire logic [FILT_W-1:0] cfg_mon_filt,
   input wire logic cfg_mon_act
);
   function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
      sat_inc = (&v) ? v : v + 1'b1;
   endfunction

   mprs_xcv_t xcv_ff;
   mprs_xcv_t nxt_xcv;
   mprs_pwr_t pwr_ff;
   mprs_pwr_t nxt_pwr;
   mprs_wd_t wd_ff;
   mprs_wd_t nxt_wd;
   logic [CNT_W-1:0] cfg_cnt_ff;
   logic [CNT_W-1:0] wd_cnt_ff;
   logic [CNT_W-1:0] wd_open_ff;
   logic [CNT_W-1:0] wd_close_ff;
   logic [1:0] wd_act1_ff;
   logic [1:0] wd_act2_ff;
   logic [FILT_W-1:0] mon_filt_ff;
   logic mon_act_ff;
   logic [3:0] rail_flt;
   logic hard_req;
   logic warm_req;

   // transceiver reset is the inverted fatal fault line
   wire xcv_rst = ~fatal_fault_n;

   // programmable watchdog and monitor settings, OTP defaults at reset
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         wd_open_ff <= CNT_W'(WD_OPEN);
         wd_close_ff <= CNT_W'(WD_CLOSE);
         wd_act1_ff <= OTP_WD_ACT1;
         wd_act2_ff <= OTP_WD_ACT2;
         mon_filt_ff <= OTP_MON_FILT;
         mon_act_ff <= OTP_MON_ACT;
      end
      else
      begin
         if (cfg_wd_wr)
         begin
            wd_open_ff <= cfg_wd_open;
            wd_close_ff <= cfg_wd_close;
            wd_act1_ff <= cfg_wd_act1;
            wd_act2_ff <= cfg_wd_act2;
         end
         if (cfg_mon_wr)
         begin
            mon_filt_ff <= cfg_mon_filt;
            mon_act_ff <= cfg_mon_act;
         end
      end
   end

   // rail fault filters, one per monitored condition
   wire [3:0] rail_raw = {proc_core_rail_ov, proc_core_rail_uv, proc_io_rail_ov, proc_io_rail_uv};
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_flt
         mprs_rail_filter u_flt (
            .ref_clk(ref_clk),
            .reset(reset),
            .flt_len(mon_filt_ff),
            .fault_raw(rail_raw[gi]),
            .fault_ff(rail_flt[gi])
         );
      end
   endgenerate
   wire rail_fault = (|rail_flt) && mon_act_ff;

   // transceiver mode machine
   wire cfg_expired = (cfg_cnt_ff >= CNT_W'(CFG_TIMEOUT));
   always_comb
   begin
      nxt_xcv = xcv_ff;
      case (xcv_ff)
         XCV_STANDBY:
         begin
            if (xcv_rst)
               nxt_xcv = XCV_SLEEP;
            else if (xcv_config_done && pwr_ff == PWR_RUN)
               nxt_xcv = XCV_NORMAL;
            else if (cfg_expired)
               nxt_xcv = XCV_SLEEP;
         end
         XCV_NORMAL:
         begin
            if (xcv_rst)
               nxt_xcv = XCV_SLEEP;
         end
         XCV_SLEEP:
         begin
            // wake is ignored while the fault still holds the transceiver in reset
            if (bus_wakeup && !xcv_rst)
               nxt_xcv = XCV_STANDBY;
         end
         default: nxt_xcv = XCV_STANDBY;
      endcase
   end

   // configuration timer runs from the processor leaving reset
   wire [CNT_W-1:0] nxt_cfg_cnt = (xcv_ff == XCV_STANDBY && pwr_ff == PWR_RUN)
      ? sat_inc(cfg_cnt_ff) : '0;

   // power chain: regulator, power-management stage, processor
   wire reg_on = (nxt_xcv != XCV_SLEEP);
   always_comb
   begin
      nxt_pwr = pwr_ff;
      case (pwr_ff)
         PWR_OFF:
         begin
            if (reg_on && reg_power_good)
               nxt_pwr = PWR_PMIC;
         end
         PWR_PMIC:
         begin
            if (!reg_on || !reg_power_good)
               nxt_pwr = PWR_OFF;
            else if (rails_in_range)
               nxt_pwr = PWR_RUN;
         end
         PWR_RUN:
         begin
            // losing the regulator restarts the full ordering
            if (!reg_on || !reg_power_good)
               nxt_pwr = PWR_OFF;
            else if (!rails_in_range)
               nxt_pwr = PWR_PMIC;
         end
         default: nxt_pwr = PWR_OFF;
      endcase
   end

   // window watchdog: kick must fall between open and close counts
   wire kick_early = watchdog_kick_in && (wd_cnt_ff < wd_open_ff);
   wire kick_ok = watchdog_kick_in && !kick_early;
   wire wd_late = (wd_cnt_ff >= wd_close_ff);
   wire wd_expire = kick_early || wd_late;
   wire warm_done = (wd_cnt_ff >= CNT_W'(WARM_PULSE));
   wire wd_run = (pwr_ff == PWR_RUN);
   always_comb
   begin
      nxt_wd = wd_ff;
      case (wd_ff)
         WD_IDLE:
         begin
            if (wd_run)
               nxt_wd = WD_ARMED;
         end
         WD_ARMED:
         begin
            if (wd_expire)
               nxt_wd = (wd_act1_ff == ACT_NONE) ? WD_ARMED : WD_WARM;
         end
         WD_WARM:
         begin
            if (warm_done)
               nxt_wd = WD_RECOVER;
         end
         WD_RECOVER:
         begin
            // only a good kick proves the processor came back
            if (kick_ok)
               nxt_wd = WD_ARMED;
            else if (wd_expire)
               nxt_wd = WD_IDLE;
         end
         default: nxt_wd = WD_IDLE;
      endcase
      if (!wd_run)
         nxt_wd = WD_IDLE;
   end
   wire wd_restart = (nxt_wd != wd_ff) || kick_ok;
   wire [CNT_W-1:0] nxt_wd_cnt = wd_restart ? '0 : sat_inc(wd_cnt_ff);

   wire act1_hard = (wd_act1_ff == ACT_HARD);
   // a power drop also sends the watchdog idle; only a real second expiry escalates
   wire esc_hard = (wd_ff == WD_RECOVER) && wd_run && wd_expire && !kick_ok
      && (wd_act2_ff != ACT_NONE);
   wire stage1 = (wd_ff == WD_ARMED) && (nxt_wd == WD_WARM);
   wire wd_hard = esc_hard || (stage1 && act1_hard);
   // hard reset wins: warm reset is suppressed while hard_req is set
   assign hard_req = (nxt_pwr != PWR_RUN) || rail_fault || wd_hard;
   assign warm_req = (nxt_wd == WD_WARM) && !act1_hard && !hard_req;

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         xcv_ff <= XCV_STANDBY;
         pwr_ff <= PWR_OFF;
         wd_ff <= WD_IDLE;
         cfg_cnt_ff <= '0;
         wd_cnt_ff <= '0;
      end
      else
      begin
         xcv_ff <= nxt_xcv;
         pwr_ff <= (rail_fault && nxt_pwr == PWR_RUN) ? PWR_PMIC : nxt_pwr;
         wd_ff <= nxt_wd;
         cfg_cnt_ff <= nxt_cfg_cnt;
         wd_cnt_ff <= nxt_wd_cnt;
      end
   end

   // registered outputs
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         reg_enable <= 1'b1;
         supply_inhibit_ctl <= 1'b1;
         pmic_reset_n <= 1'b0;
         xcv_normal <= 1'b0;
         radar_hard_reset_n <= 1'b0;
         radar_warm_reset_n <= 1'b1;
         watchdog_reset_out <= 1'b0;
      end
      else
      begin
         supply_inhibit_ctl <= reg_on;
         reg_enable <= reg_on;
         pmic_reset_n <= (nxt_pwr != PWR_OFF);
         xcv_normal <= (nxt_xcv == XCV_NORMAL);
         radar_hard_reset_n <= ~hard_req;
         radar_warm_reset_n <= ~warm_req;
         watchdog_reset_out <= warm_req || wd_hard;
      end
   end
endmodule
`default_nettype wire

// ===== verification/mprs_supervisor_monitor.sv
// Purpose: port checker for the power and reset supervisor
// Assumes: bound to mprs_supervisor with WARM_PULSE of 8
// Notes: short rail faults must leave the hard reset alone
`timescale 1ns/1ps
`default_nettype none
module mprs_supervisor_monitor
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // power chain
   input wire logic reg_power_good,
   input wire logic rails_in_range,
   input wire logic reg_enable,
   input wire logic supply_inhibit_ctl,
   input wire logic pmic_reset_n,
   // transceiver and processor
   input wire logic xcv_config_done,
   input wire logic bus_wakeup,
   input wire logic xcv_normal,
   input wire logic fatal_fault_n,
   input wire logic radar_hard_reset_n,
   input wire logic radar_warm_reset_n,
   // rail faults
   input wire logic proc_io_rail_uv,
   input wire logic proc_io_rail_ov,
   input wire logic proc_core_rail_uv,
   input wire logic proc_core_rail_ov
);
   wire logic any_flt = proc_io_rail_uv | proc_io_rail_ov | proc_core_rail_uv | proc_core_rail_ov;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   AST_RST_OUT: assert property ($fell(reset) |-> reg_enable && !pmic_reset_n
      && !radar_hard_reset_n && radar_warm_reset_n && !xcv_normal) else $error("bad reset state");
   AST_INH_EQ: assert property (supply_inhibit_ctl == reg_enable)
      else $error("inhibit differs from enable");
   AST_PMIC_REL: assert property ($rose(pmic_reset_n) |-> $past(reg_power_good))
      else $error("pmic released without power good");
   AST_PMIC_HOLD: assert property (!reg_power_good |=> !pmic_reset_n)
      else $error("pmic out of reset without power good");
   AST_HARD_REL: assert property ($rose(radar_hard_reset_n) |-> $past(rails_in_range))
      else $error("hard reset released with rails out of range");
   AST_NORMAL: assert property ($rose(xcv_normal) |-> $past(xcv_config_done))
      else $error("normal mode without configuration");
   AST_FATAL: assert property (!fatal_fault_n |=> !reg_enable && !xcv_normal)
      else $error("fatal fault did not power down");
   AST_WAKE: assert property ($rose(reg_enable) |-> $past(bus_wakeup))
      else $error("regulator enabled without wake-up");
   AST_WARM_LEN: assert property ($fell(radar_warm_reset_n) |-> (!radar_warm_reset_n)[*8])
      else $error("warm reset pulse too short");
   AST_HARD_WINS: assert property (!radar_hard_reset_n |-> radar_warm_reset_n)
      else $error("warm and hard reset together");
   AST_FILT: assert property (radar_hard_reset_n && $rose(any_flt) ##1 any_flt ##1 !any_flt
      |-> radar_hard_reset_n[*3]) else $error("short rail fault caused reset");
   cover property ($fell(radar_warm_reset_n));
   cover property ($rose(xcv_normal));
   cover property ($fell(reg_enable));
endmodule
`default_nettype wire

// ===== verification/mprs_radar_model.sv
// Purpose: behavioural radar processor and regulator around the supervisor
// Assumes: kicks every 40 cycles, inside the shortened window
// Notes: kick_en and cfg_en let the bench withhold kicks or setup
`timescale 1ns/1ps
`default_nettype none
module mprs_radar_model
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // from the supervisor
   input wire logic reg_enable,
   input wire logic pmic_reset_n,
   input wire logic radar_hard_reset_n,
   input wire logic radar_warm_reset_n,
   // bench control
   input wire logic kick_en,
   input wire logic cfg_en,
   // to the supervisor
   output logic reg_power_good,
   output logic rails_in_range,
   output logic watchdog_kick_in,
   output logic xcv_config_done
);
   logic [2:0] pg_ff;
   logic [5:0] run_ff;
   logic rails_ff;
   logic cfg_ff;
   wire logic halted = !radar_hard_reset_n || !radar_warm_reset_n;
   // regulator needs a few cycles to come up, so power good lags
   always_ff @(posedge ref_clk)
   begin
      pg_ff <= reset ? 3'h0 : {pg_ff[1:0], reg_enable};
      rails_ff <= !reset && pmic_reset_n && reg_power_good;
      run_ff <= (reset || halted || run_ff == 6'h27) ? 6'h0 : run_ff + 6'h1;
      cfg_ff <= !(reset || halted) && (cfg_ff || run_ff == 6'h5);
   end
   assign reg_power_good = pg_ff[2];
   assign rails_in_range = rails_ff;
   assign watchdog_kick_in = kick_en && run_ff == 6'h27;
   assign xcv_config_done = cfg_en && cfg_ff;
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// Purpose: self-checking bench for the power and reset supervisor
// Assumes: shortened timeout and watchdog counts
// Notes: checks compare masked output snapshots
`timescale 1ns/1ps
`default_nettype none
module testbench
   import mprs_pkg::*;
;
   logic ref_clk = 1'h0;
   logic reset = 1'h1;
   logic reg_power_good, rails_in_range, reg_enable, supply_inhibit_ctl, pmic_reset_n;
   logic xcv_config_done, xcv_normal, watchdog_kick_in, watchdog_reset_out;
   logic radar_hard_reset_n, radar_warm_reset_n;
   logic bus_wakeup = 1'h0, fatal_fault_n = 1'h1, kick_en = 1'h1, cfg_en = 1'h1;
   logic cfg_wd_wr = 1'h0, cfg_mon_wr = 1'h0, cfg_mon_act = 1'h0;
   logic [CNT_W-1:0] cfg_wd_open = 24'h0, cfg_wd_close = 24'h0;
   logic [1:0] cfg_wd_act1 = ACT_WARM, cfg_wd_act2 = ACT_HARD;
   logic [FILT_W-1:0] cfg_mon_filt = 12'h0;
   logic [3:0] flt = 4'h0;
   logic [7:0] rnd = 8'h2f;
   logic [11:0] exp_q[$];
   logic [11:0] cur;
   int errors = 0, checks = 0, cyc = 0;
   event got;
   wire logic proc_io_rail_uv = flt[0];
   wire logic proc_io_rail_ov = flt[1];
   wire logic proc_core_rail_uv = flt[2];
   wire logic proc_core_rail_ov = flt[3];
   wire logic [5:0] obs = {reg_enable, pmic_reset_n, radar_hard_reset_n, radar_warm_reset_n,
      xcv_normal, watchdog_reset_out};
   mprs_supervisor #(.CFG_TIMEOUT(200), .WD_OPEN(10), .WD_CLOSE(100), .WARM_PULSE(8)) u_dut (
      .ref_clk(ref_clk),
      .reset(reset),
      .reg_power_good(reg_power_good),
      .rails_in_range(rails_in_range),
      .reg_enable(reg_enable),
      .supply_inhibit_ctl(supply_inhibit_ctl),
      .pmic_reset_n(pmic_reset_n),
      .xcv_config_done(xcv_config_done),
      .bus_wakeup(bus_wakeup),
      .xcv_normal(xcv_normal),
      .watchdog_kick_in(watchdog_kick_in),
      .fatal_fault_n(fatal_fault_n),
      .radar_hard_reset_n(radar_hard_reset_n),
      .radar_warm_reset_n(radar_warm_reset_n),
      .watchdog_reset_out(watchdog_reset_out),
      .proc_io_rail_uv(proc_io_rail_uv),
      .proc_io_rail_ov(proc_io_rail_ov),
      .proc_core_rail_uv(proc_core_rail_uv),
      .proc_core_rail_ov(proc_core_rail_ov),
      .cfg_wd_wr(cfg_wd_wr),
      .cfg_wd_open(cfg_wd_open),
      .cfg_wd_close(cfg_wd_close),
      .cfg_wd_act1(cfg_wd_act1),
      .cfg_wd_act2(cfg_wd_act2),
      .cfg_mon_wr(cfg_mon_wr),
      .cfg_mon_filt(cfg_mon_filt),
      .cfg_mon_act(cfg_mon_act)
   );
   mprs_radar_model u_model (
      .ref_clk(ref_clk),
      .reset(reset),
      .reg_enable(reg_enable),
      .pmic_reset_n(pmic_reset_n),
      .radar_hard_reset_n(radar_hard_reset_n),
      .radar_warm_reset_n(radar_warm_reset_n),
      .kick_en(kick_en),
      .cfg_en(cfg_en),
      .reg_power_good(reg_power_good),
      .rails_in_range(rails_in_range),
      .watchdog_kick_in(watchdog_kick_in),
      .xcv_config_done(xcv_config_done)
   );
   always #12.5 ref_clk = ~ref_clk;
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task finish_test();
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // expected value in the upper half, mask in the lower
   task chk(input logic [11:0] em);
      exp_q.push_back(em);
      -> got;
   endtask
   task automatic await(input int b, input logic v, input int n);
      repeat (n) if (obs[b] !== v) @(negedge ref_clk);
   endtask
   task wake();
      @(posedge ref_clk);
      fatal_fault_n <= 1'h1;
      bus_wakeup <= 1'h1;
      @(posedge ref_clk);
      bus_wakeup <= 1'h0;
   endtask
   always @(got)
   begin
      // drain every note: two checks may be posted within one time step
      while (exp_q.size() > 0)
      begin
         cur = exp_q.pop_front();
         checks++;
         if ((obs & cur[5:0]) !== cur[11:6]
            || (cur[5] && supply_inhibit_ctl !== cur[11]))
         begin
            errors++;
            $display("Error at %0t: outputs %b expected %b", $time, obs, cur[11:6]);
         end
      end
   end
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         errors++;
         $display("Error at %0t: timeout", $time);
         finish_test();
      end
   end
   initial
   begin
      repeat (12) @(posedge ref_clk);
      reset <= 1'h0;
      @(negedge ref_clk);
      chk({6'h24, 6'h3f});
      await(1, 1'h1, 300);
      chk({6'h3e, 6'h3f});
      @(posedge ref_clk);
      cfg_mon_filt <= 12'h4;
      cfg_mon_act <= 1'h1;
      cfg_mon_wr <= 1'h1;
      @(posedge ref_clk);
      cfg_mon_wr <= 1'h0;
      for (int i = 0; i < 4; i++)
      begin
         @(posedge ref_clk);
         flt <= 4'h1 << i;
         repeat (2) @(posedge ref_clk);
         flt <= 4'h0;
         repeat (8) @(negedge ref_clk);
         chk({6'h08, 6'h08});
         @(posedge ref_clk);
         flt <= 4'h1 << i;
         repeat (12) @(negedge ref_clk);
         chk({6'h00, 6'h08});
         @(posedge ref_clk);
         flt <= 4'h0;
         await(3, 1'h1, 300);
      end
      // monitor action off: a long rail fault must leave the processor running
      @(posedge ref_clk);
      cfg_mon_act <= 1'h0;
      cfg_mon_wr <= 1'h1;
      @(posedge ref_clk);
      cfg_mon_wr <= 1'h0;
      flt <= 4'h8;
      repeat (12) @(negedge ref_clk);
      chk({6'h08, 6'h08});
      @(posedge ref_clk);
      flt <= 4'h0;
      for (int k = 0; k < 2; k++)
      begin
         @(posedge ref_clk);
         rnd = lfsr(rnd);
         cfg_wd_open <= CNT_W'(rnd % 8'h1e) + 24'h1;
         cfg_wd_close <= CNT_W'(rnd % 8'h28) + 24'h3c;
         cfg_wd_act1 <= k ? ACT_HARD : ACT_WARM;
         cfg_wd_wr <= 1'h1;
         kick_en <= 1'h0;
         @(posedge ref_clk);
         cfg_wd_wr <= 1'h0;
         if (k == 0)
         begin
            await(2, 1'h0, 300);
            chk({6'h09, 6'h0d});
         end
         await(3, 1'h0, 400);
         chk({6'h04, 6'h0c});
         @(posedge ref_clk);
         kick_en <= 1'h1;
         await(3, 1'h1, 300);
      end
      @(posedge ref_clk);
      fatal_fault_n <= 1'h0;
      repeat (2) @(negedge ref_clk);
      chk({6'h00, 6'h22});
      await(3, 1'h0, 20);
      chk({6'h00, 6'h38});
      wake();
      await(1, 1'h1, 300);
      chk({6'h3e, 6'h3f});
      @(posedge ref_clk);
      cfg_en <= 1'h0;
      fatal_fault_n <= 1'h0;
      await(3, 1'h0, 20);
      wake();
      await(3, 1'h1, 300);
      await(5, 1'h0, 300);
      chk({6'h00, 6'h22});
      @(posedge ref_clk);
      cfg_en <= 1'h1;
      wake();
      await(1, 1'h1, 300);
      chk({6'h3e, 6'h3f});
      @(negedge ref_clk);
      finish_test();
   end
endmodule
bind mprs_supervisor mprs_supervisor_monitor u_mon (
   .ref_clk(ref_clk),
   .reset(reset),
   .reg_power_good(reg_power_good),
   .rails_in_range(rails_in_range),
   .reg_enable(reg_enable),
   .supply_inhibit_ctl(supply_inhibit_ctl),
   .pmic_reset_n(pmic_reset_n),
   .xcv_config_done(xcv_config_done),
   .bus_wakeup(bus_wakeup),
   .xcv_normal(xcv_normal),
   .fatal_fault_n(fatal_fault_n),
   .radar_hard_reset_n(radar_hard_reset_n),
   .radar_warm_reset_n(radar_warm_reset_n),
   .proc_io_rail_uv(proc_io_rail_uv),
   .proc_io_rail_ov(proc_io_rail_ov),
   .proc_core_rail_uv(proc_core_rail_uv),
   .proc_core_rail_ov(proc_core_rail_ov)
);
`default_nettype wire
